// ---- verilog/sweep_and_amplitude_ramp.v ----
// Linear sweep engine, accumulator clearing and amplitude scale ramp for one synthesizer channel
//
// Overview of operation
// [RULE_01] Step word is 32 bits for frequency, 14 for phase, 10 for amplitude.
// [RULE_02] Rising and falling interval words are 8 bits, counted in sync-clock periods.
// [RULE_03] Rising direction uses rising step and interval; falling uses falling ones.
// [RULE_04] Accumulator overflow wraps and sweeping continues; software keeps steps small. The code clamps any step past the end value instead.
// [RULE_05] With no-dwell set, sweep accumulator returns to zero at end value.
// [RULE_06] Dwell per step equals interval word in sync periods, valid 1 to 255.
// [RULE_07] Step and interval words may be rewritten mid-sweep and take effect.
// [RULE_08] Software selects frequency sweep: type 10, level 00, sweep enable 1.
// [RULE_09] Profile rising edge applies rising step and loads rising interval.
// [RULE_10] Rising sweep accumulates until output equals end value, then holds.
// [RULE_11] Profile falling edge sweeps down with falling words to start value, then holds.
// [RULE_12] No-dwell: after reaching end, output reverts to start, waits for high profile.
// [RULE_13] No-dwell: falling step and falling interval have no effect.
// [RULE_14] Continuous-clear bits 3 and 1 hold sweep and phase accumulators at zero.
// [RULE_15] Auto-clear bits 4 and 2 clear accumulator once per update or profile change.
// [RULE_16] Multiplier enable low bypasses output scaling.
// [RULE_17] Mode 10 uses the software 10-bit scale field.
// [RULE_18] Mode 11 uses internal 10-bit counter, up with ramp pin high, down when low.
// [RULE_19] Scale counter steps at the 8-bit ramp rate field.
// [RULE_20] Step field 00,01,10,11 gives counter steps 1,2,4,8.
// [RULE_21] Automatic ramp stops at the programmed scale value, not full scale. The code ramps to full scale when that value is zero.
// [RULE_22] Ramp timer is 8-bit down counter reloading with rate on reaching one.
// [RULE_23] Load-timer bit also reloads ramp timer on update or profile change.
// [RULE_24] Start value from profile register 0, end from profile 1, MSB-aligned.
// [RULE_25] Writes sit in buffer until sync-sampled update moves them to active registers.
// [RULE_26] On sweep timer expiry add or subtract selected step, reload interval.
// [RULE_27] Scale counter saturates at zero and at its limit.
`include "sweep_ramp_map.vh"
`timescale 1ns/1ns
`default_nettype none

module sweep_and_amplitude_ramp #(
    parameter AW = 5
) (
    // Clock and reset
    input wire SYS_CLK,
    input wire SRST,
    // Register write port into the I/O buffer
    input wire WR_EN,
    input wire [AW-1:0] WR_ADDR,
    input wire [31:0] WR_DATA,
    input wire IO_UPDATE,
    // Register read port of active registers
    input wire [AW-1:0] RD_ADDR,
    output reg [31:0] RD_DATA,
    // Pins from the external controller
    input wire PROFILE_PIN,
    input wire RAMP_PIN,
    // Results
    output reg [31:0] SWEEP_VALUE,
    output reg [9:0] SCALE_FACTOR,
    output reg SCALE_BYPASS,
    output reg CLEAR_PHASE,
    output reg SYNC_CLK_OUT
);

    // Inactive buffer copies
    reg [23:0] buf_cfc_q;
    reg [23:0] buf_arc_q;
    reg [15:0] buf_int_q;
    reg [31:0] buf_rise_q;
    reg [31:0] buf_fall_q;
    reg [31:0] buf_start_q;
    reg [31:0] buf_end_q;
    // Active registers
    reg [23:0] cfc_q;
    reg [23:0] arc_q;
    reg [15:0] int_q;
    reg [31:0] rise_q;
    reg [31:0] fall_q;
    reg [31:0] start_q;
    reg [31:0] end_q;

    // Sync clock divider
    // The free-running count restarts at reset so the sync phase is repeatable
    // Everything below that moves sweep or ramp state, except a continuous sweep clear, waits for the tick at count three
    reg [1:0] div_q;
    wire sync_tick = (div_q == `SYNC_DIV);

    // Three-stage synchronisers for pins
    // Two agreeing stages filter a single-cycle glitch on a pin
    // The cost is about four system cycles of latency on every pin
    reg [2:0] upd_s_q;
    reg [2:0] prof_s_q;
    reg [2:0] ramp_s_q;
    reg upd_lvl_q;
    reg prof_lvl_q;
    reg ramp_lvl_q;
    reg upd_prev_q;
    reg prof_prev_q;
    reg upd_pend_q;
    reg prof_chg_pend_q;
    reg prof_rise_pend_q;
    reg prof_fall_pend_q;

    always @(posedge SYS_CLK) begin
        if (SRST) begin
            div_q <= 2'h0;
            upd_s_q <= 3'h0;
            prof_s_q <= 3'h0;
            ramp_s_q <= 3'h0;
            upd_lvl_q <= 1'b0;
            prof_lvl_q <= 1'b0;
            ramp_lvl_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            upd_s_q <= {upd_s_q[1:0], IO_UPDATE};
            prof_s_q <= {prof_s_q[1:0], PROFILE_PIN};
            ramp_s_q <= {ramp_s_q[1:0], RAMP_PIN};
            // A change counts once stages two and three agree
            if (upd_s_q[1] == upd_s_q[2]) upd_lvl_q <= upd_s_q[2];
            if (prof_s_q[1] == prof_s_q[2]) prof_lvl_q <= prof_s_q[2];
            if (ramp_s_q[1] == ramp_s_q[2]) ramp_lvl_q <= ramp_s_q[2];
        end
    end

    // Events caught at system rate, consumed at the next sync tick
    // A pending flag set in the very cycle of a tick survives to the next tick
    // Set wins over clear, so an edge is never lost between ticks
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            upd_prev_q <= 1'b0;
            prof_prev_q <= 1'b0;
            upd_pend_q <= 1'b0;
            prof_chg_pend_q <= 1'b0;
            prof_rise_pend_q <= 1'b0;
            prof_fall_pend_q <= 1'b0;
        end else begin
            upd_prev_q <= upd_lvl_q;
            prof_prev_q <= prof_lvl_q;
            // Update is sampled on the sync clock edge
            // A pulse of two or more system cycles, though shorter than a sync period, is still caught: its edge sets a pending flag
            if (sync_tick) upd_pend_q <= 1'b0;
            if (upd_lvl_q && !upd_prev_q) upd_pend_q <= 1'b1; // see [RULE_25]
            if (sync_tick) begin
                prof_chg_pend_q <= 1'b0;
                prof_rise_pend_q <= 1'b0;
                prof_fall_pend_q <= 1'b0;
            end
            if (prof_lvl_q != prof_prev_q) begin
                prof_chg_pend_q <= 1'b1;
                prof_rise_pend_q <= prof_lvl_q;
                prof_fall_pend_q <= !prof_lvl_q;
            end
        end
    end

    wire upd_ev = sync_tick && upd_pend_q;
    wire prof_chg = sync_tick && prof_chg_pend_q;
    wire prof_rise = sync_tick && prof_rise_pend_q;
    wire prof_fall = sync_tick && prof_fall_pend_q;

    // Buffer writes, then transfer on update
    // Writes never disturb the running sweep until an update moves them across
    // Unmapped indices are dropped silently
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            buf_cfc_q <= `RST_CHAN_CTRL;
            buf_arc_q <= `RST_AMP_CTRL;
            buf_int_q <= `RST_INTERVALS;
            buf_rise_q <= `RST_WORD;
            buf_fall_q <= `RST_WORD;
            buf_start_q <= `RST_WORD;
            buf_end_q <= `RST_WORD;
            cfc_q <= `RST_CHAN_CTRL;
            arc_q <= `RST_AMP_CTRL;
            int_q <= `RST_INTERVALS;
            rise_q <= `RST_WORD;
            fall_q <= `RST_WORD;
            start_q <= `RST_WORD;
            end_q <= `RST_WORD;
        end else begin
            if (WR_EN) begin
                case (WR_ADDR)
                    `ADDR_CHAN_CTRL: buf_cfc_q <= WR_DATA[23:0];
                    `ADDR_AMP_CTRL: buf_arc_q <= WR_DATA[23:0];
                    `ADDR_INTERVALS: buf_int_q <= WR_DATA[15:0];
                    `ADDR_RISE_STEP: buf_rise_q <= WR_DATA;
                    `ADDR_FALL_STEP: buf_fall_q <= WR_DATA;
                    `ADDR_START_WORD: buf_start_q <= WR_DATA;
                    `ADDR_END_WORD: buf_end_q <= WR_DATA;
                    default: ;
                endcase
            end
            // Step and interval words land mid-sweep too, allowing piecewise ramps
            if (upd_ev) begin // see [RULE_25] see [RULE_07]
                cfc_q <= buf_cfc_q;
                arc_q <= buf_arc_q;
                int_q <= buf_int_q;
                rise_q <= buf_rise_q;
                fall_q <= buf_fall_q;
                start_q <= buf_start_q;
                end_q <= buf_end_q;
            end
        end
    end

    // Read back active state
    // Only active copies are visible; the buffer cannot be read back
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            RD_DATA <= 32'h00000000;
        end else begin
            case (RD_ADDR)
                `ADDR_CHAN_CTRL: RD_DATA <= {8'h00, cfc_q};
                `ADDR_AMP_CTRL: RD_DATA <= {8'h00, arc_q};
                `ADDR_INTERVALS: RD_DATA <= {16'h0000, int_q};
                `ADDR_RISE_STEP: RD_DATA <= rise_q;
                `ADDR_FALL_STEP: RD_DATA <= fall_q;
                `ADDR_START_WORD: RD_DATA <= start_q;
                `ADDR_END_WORD: RD_DATA <= end_q;
                default: RD_DATA <= 32'h00000000;
            endcase
        end
    end

    // Sweep width masks: phase and amplitude words are MSB-aligned
    // Low bits below the sweep width are ignored, as a narrower accumulator would
    wire [1:0] sweep_type = cfc_q[`CFC_SWEEP_TYPE_HI:`CFC_SWEEP_TYPE_LO];
    reg [31:0] mask;
    always @* begin
        case (sweep_type) // see [RULE_01] see [RULE_24]
            `SWEEP_PHASE: mask = 32'hfffc0000;
            `SWEEP_AMP: mask = 32'hffc00000;
            default: mask = 32'hffffffff;
        endcase
    end

    wire no_dwell = cfc_q[`CFC_NO_DWELL];
    wire sweep_en = cfc_q[`CFC_SWEEP_EN];
    wire [31:0] s_start = start_q & mask;
    wire [31:0] s_end = end_q & mask;
    wire [31:0] s_rise = rise_q & mask;
    wire [31:0] s_fall = fall_q & mask;

    // Sweep states
    // Hold keeps the output at the end or start value until the next profile edge
    // Idle shows the start value and waits for a rising edge
    localparam ST_IDLE = 2'h0;
    localparam ST_UP = 2'h1;
    localparam ST_DOWN = 2'h2;
    localparam ST_HOLD = 2'h3;
    reg [1:0] st_q;
    reg [31:0] acc_q;
    reg [7:0] stimer_q;
    wire [31:0] dist_up = s_end - s_start;
    wire [31:0] up_sum = acc_q + s_rise;
    // Clear requests are decoded per system cycle; the events carry the tick already
    wire clr_sweep = cfc_q[`CFC_CONT_CLR_SWEEP] ||
        (cfc_q[`CFC_AUTO_CLR_SWEEP] && (upd_ev || prof_chg));

    // Sweep engine: the accumulator holds the distance from the start value
    // Only the sync tick or a continuous clear moves it, so every dwell is a whole number of sync periods
    // A clear outranks a profile edge; an auto clear releases in the same tick
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            st_q <= ST_IDLE;
            acc_q <= 32'h00000000;
            stimer_q <= 8'h01;
        end else if (clr_sweep) begin
            acc_q <= 32'h00000000; // see [RULE_14] see [RULE_15]
            // Continuous clear pins the engine idle; auto clear lets a rising edge start at once
            if (prof_rise && sweep_en && !cfc_q[`CFC_CONT_CLR_SWEEP]) begin
                st_q <= ST_UP; // see [RULE_09]
                stimer_q <= int_q[`INT_RISE_HI:`INT_RISE_LO]; // see [RULE_02]
            end else begin
                st_q <= ST_IDLE;
            end
        end else if (sync_tick && sweep_en) begin
            if (prof_rise) begin
                // Loading the full interval means the first step lands one dwell after the edge
                st_q <= ST_UP; // see [RULE_09]
                stimer_q <= int_q[`INT_RISE_HI:`INT_RISE_LO]; // see [RULE_02]
            end else if (prof_fall && !no_dwell) begin
                st_q <= ST_DOWN; // see [RULE_11] see [RULE_13]
                stimer_q <= int_q[`INT_FALL_HI:`INT_FALL_LO];
            end else if (st_q == ST_UP || st_q == ST_DOWN) begin
                if (stimer_q > 8'h01) begin
                    stimer_q <= stimer_q - 8'h01; // see [RULE_06]
                end else if (st_q == ST_UP) begin
                    stimer_q <= int_q[`INT_RISE_HI:`INT_RISE_LO]; // see [RULE_26] see [RULE_03]
                    // A step that would pass the end value, even by wrapping, is clamped onto it
                    if (acc_q == dist_up) begin
                        if (no_dwell) begin
                            acc_q <= 32'h00000000; // see [RULE_05] see [RULE_12]
                            st_q <= ST_IDLE;
                        end else begin
                            st_q <= ST_HOLD; // see [RULE_10]
                        end
                    end else if (up_sum - acc_q > dist_up - acc_q) begin
                        // A final partial step clamps onto the end value
                        acc_q <= dist_up;
                    end else begin
                        acc_q <= up_sum; // see [RULE_04]
                    end
                end else begin
                    // Falling clamps at zero so the output never undershoots the start value
                    stimer_q <= int_q[`INT_FALL_HI:`INT_FALL_LO]; // see [RULE_03]
                    if (acc_q == 32'h00000000) begin
                        st_q <= ST_HOLD; // see [RULE_11]
                    end else if (s_fall > acc_q) begin
                        acc_q <= 32'h00000000;
                    end else begin
                        acc_q <= acc_q - s_fall; // see [RULE_26]
                    end
                end
            end
        end
    end

    // Amplitude ramp: timer, counter, selection
    // The timer runs whenever the block is out of reset, not only in automatic mode,
    // so a change to automatic mode steps within one rate period
    // A rate of zero behaves like one: the timer expires on every tick
    reg [7:0] atimer_q;
    reg [9:0] acount_q;
    wire [7:0] arate = arc_q[`ARC_RATE_HI:`ARC_RATE_LO];
    wire [9:0] alimit = arc_q[`ARC_SCALE_HI:`ARC_SCALE_LO];
    wire [10:0] astep = 11'h001 << arc_q[`ARC_STEP_HI:`ARC_STEP_LO]; // see [RULE_20]
    wire [10:0] a_up = {1'b0, acount_q} + astep;
    wire [10:0] lim_ext = (alimit == 10'h000) ? 11'h3ff : {1'b0, alimit};
    wire a_auto = arc_q[`ARC_MULT_EN] && arc_q[`ARC_AUTO];
    wire a_tick = (atimer_q <= 8'h01);

    always @(posedge SYS_CLK) begin
        if (SRST) begin
            atimer_q <= 8'h01;
            acount_q <= 10'h000;
        end else if (sync_tick) begin
            // A forced load restarts the full rate period
            if (arc_q[`ARC_LOAD_TIMER] && (upd_ev || prof_chg)) begin
                atimer_q <= arate; // see [RULE_23]
            end else if (a_tick) begin
                atimer_q <= arate; // see [RULE_22]
            end else begin
                atimer_q <= atimer_q - 8'h01; // see [RULE_19]
            end
            if (a_auto && a_tick) begin
                if (ramp_lvl_q) begin
                    // Limit defaults to full scale when the scale field is zero
                    acount_q <= (a_up > lim_ext) ? lim_ext[9:0] : a_up[9:0]; // see [RULE_18] see [RULE_21] see [RULE_27]
                end else begin
                    acount_q <= ({1'b0, acount_q} < astep) ? 10'h000 : acount_q - astep[9:0]; // see [RULE_27]
                end
            end
        end
    end

    // Registered outputs
    // Each output is a flop, so results trail the internal state by one cycle
    // The phase clear is a level for continuous clear and a one-cycle pulse for auto clear
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            SWEEP_VALUE <= 32'h00000000;
            SCALE_FACTOR <= 10'h000;
            SCALE_BYPASS <= 1'b1;
            CLEAR_PHASE <= 1'b0;
            SYNC_CLK_OUT <= 1'b0;
        end else begin
            SWEEP_VALUE <= s_start + acc_q;
            SCALE_BYPASS <= !arc_q[`ARC_MULT_EN]; // see [RULE_16]
            SCALE_FACTOR <= a_auto ? acount_q : alimit; // see [RULE_17]
            CLEAR_PHASE <= cfc_q[`CFC_CONT_CLR_PHASE] ||
                (cfc_q[`CFC_AUTO_CLR_PHASE] && (upd_ev || prof_chg)); // see [RULE_14] see [RULE_15]
            SYNC_CLK_OUT <= !div_q[1];
        end
    end

endmodule // sweep_and_amplitude_ramp
`default_nettype wire

// ---- pkg/sweep_ramp_map.vh ----
// Register map, field positions, reset values and timing for the sweep and amplitude ramp block
`ifndef SWEEP_RAMP_MAP_VH
`define SWEEP_RAMP_MAP_VH
// Register indices (printed offsets)
`define ADDR_AMP_CTRL 5'h06
`define ADDR_INTERVALS 5'h07
`define ADDR_RISE_STEP 5'h08
`define ADDR_FALL_STEP 5'h09
`define ADDR_END_WORD 5'h0a
`define ADDR_START_WORD 5'h04
`define ADDR_CHAN_CTRL 5'h03
// Channel function control fields
`define CFC_SWEEP_TYPE_HI 23
`define CFC_SWEEP_TYPE_LO 22
`define CFC_NO_DWELL 15
`define CFC_SWEEP_EN 14
`define CFC_AUTO_CLR_SWEEP 4
`define CFC_CONT_CLR_SWEEP 3
`define CFC_AUTO_CLR_PHASE 2
`define CFC_CONT_CLR_PHASE 1
// Sweep types
`define SWEEP_AMP 2'h1
`define SWEEP_FREQ 2'h2
`define SWEEP_PHASE 2'h3
// Amplitude ramp control fields
`define ARC_RATE_HI 23
`define ARC_RATE_LO 16
`define ARC_STEP_HI 15
`define ARC_STEP_LO 14
`define ARC_MULT_EN 12
`define ARC_AUTO 11
`define ARC_LOAD_TIMER 10
`define ARC_SCALE_HI 9
`define ARC_SCALE_LO 0
// Interval register fields
`define INT_FALL_HI 15
`define INT_FALL_LO 8
`define INT_RISE_HI 7
`define INT_RISE_LO 0
// Reset values
`define RST_CHAN_CTRL 24'h000000
`define RST_AMP_CTRL 24'h000000
`define RST_INTERVALS 16'h0101
`define RST_WORD 32'h00000000
// Sync clock: system clock divided by four
`define SYNC_DIV 2'h3
`endif

// ---- tb/pin_ctrl_model.sv ----
// Model of the external controller driving the update, profile and ramp pins
`timescale 1ns/1ns
`default_nettype none
module pin_ctrl_model (
    // Clock
    input wire logic SYS_CLK,
    // Pins toward the block
    output var logic IO_UPDATE,
    output var logic PROFILE_PIN,
    output var logic RAMP_PIN
);
    initial begin
        IO_UPDATE = 1'b0;
        PROFILE_PIN = 1'b0;
        RAMP_PIN = 1'b0;
    end
    // Held well over one sync period each way so the sampler cannot miss it
    task update;
        @(posedge SYS_CLK);
        IO_UPDATE <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        IO_UPDATE <= 1'b0;
        repeat (12) @(posedge SYS_CLK);
    endtask
    task pins(input logic p, input logic r);
        @(posedge SYS_CLK);
        PROFILE_PIN <= p;
        RAMP_PIN <= r;
    endtask
endmodule // pin_ctrl_model
`default_nettype wire

// ---- tb/sweep_ramp_chk_asserts.sv ----
// Port checker for the sweep and amplitude ramp block
`timescale 1ns/1ns
`default_nettype none
module sweep_ramp_chk (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic SRST,
    // Register side
    input wire logic IO_UPDATE,
    input wire logic [4:0] RD_ADDR,
    input wire logic [31:0] RD_DATA,
    // Pins and results
    input wire logic RAMP_PIN,
    input wire logic [31:0] SWEEP_VALUE,
    input wire logic [9:0] SCALE_FACTOR,
    input wire logic SCALE_BYPASS,
    input wire logic CLEAR_PHASE,
    input wire logic SYNC_CLK_OUT
);
    logic [4:0] idle_q;
    logic rd6_q;
    logic ok_q;
    logic [12:0] amp_q;
    wire amp_auto = ok_q && amp_q[12:11] == 2'b11;
    // Ramp control is only trusted once read back well after the last update
    always @(posedge SYS_CLK) begin
        rd6_q <= RD_ADDR == 5'h06;
        if (SRST || IO_UPDATE) begin
            idle_q <= 5'h00;
            ok_q <= 1'b0;
        end else begin
            idle_q <= (idle_q == 5'h1f) ? idle_q : idle_q + 5'h01;
            if (rd6_q && idle_q > 5'h0c) begin
                ok_q <= 1'b1;
                amp_q <= RD_DATA[12:0];
            end
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    property p_sync; $rose(SYNC_CLK_OUT) |-> ##4 $rose(SYNC_CLK_OUT); endproperty
    a_sync: assert property (p_sync) else $error("sync clock not divide by four");
    property p_unmap; !($past(RD_ADDR) inside {5'h03, 5'h04, [5'h06:5'h0a]}) |-> RD_DATA == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rdhold; (idle_q > 5'h0c && $stable(RD_ADDR)) |=> $stable(RD_DATA); endproperty
    a_rdhold: assert property (p_rdhold) else $error("active register moved without update");
    property p_byp_late; $changed(SCALE_BYPASS) |-> idle_q <= 5'h09; endproperty
    a_byp_late: assert property (p_byp_late) else $error("bypass changed without update");
    property p_byp; ok_q |-> SCALE_BYPASS == !amp_q[12]; endproperty
    a_byp: assert property (p_byp) else $error("bypass disagrees with enable bit");
    property p_man; (ok_q && amp_q[12:11] == 2'b10) |-> SCALE_FACTOR == amp_q[9:0]; endproperty
    a_man: assert property (p_man) else $error("manual scale not applied");
    property p_lim; (amp_auto && amp_q[9:0] != 10'h0) |-> SCALE_FACTOR <= amp_q[9:0]; endproperty
    a_lim: assert property (p_lim) else $error("auto ramp above limit");
    property p_up; RAMP_PIN [*6] ##0 amp_auto |=> SCALE_FACTOR >= $past(SCALE_FACTOR); endproperty
    a_up: assert property (p_up) else $error("scale fell while ramping up");
    property p_dn; !RAMP_PIN [*6] ##0 amp_auto |=> SCALE_FACTOR <= $past(SCALE_FACTOR); endproperty
    a_dn: assert property (p_dn) else $error("scale rose while ramping down");
    property p_sw_sp; $changed(SWEEP_VALUE) |=> $stable(SWEEP_VALUE) [*3]; endproperty
    a_sw_sp: assert property (p_sw_sp) else $error("sweep steps closer than a sync period");
    c_clr: cover property ($rose(CLEAR_PHASE));
    c_sweep: cover property ($changed(SWEEP_VALUE));
    c_top: cover property (amp_auto && SCALE_FACTOR == amp_q[9:0]);
endmodule // sweep_ramp_chk
bind sweep_and_amplitude_ramp sweep_ramp_chk i_chk (.SYS_CLK(SYS_CLK), .SRST(SRST), .IO_UPDATE(IO_UPDATE),
    .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .RAMP_PIN(RAMP_PIN), .SWEEP_VALUE(SWEEP_VALUE),
    .SCALE_FACTOR(SCALE_FACTOR), .SCALE_BYPASS(SCALE_BYPASS), .CLEAR_PHASE(CLEAR_PHASE), .SYNC_CLK_OUT(SYNC_CLK_OUT));
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the sweep and amplitude ramp block
`include "sweep_ramp_map.vh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic SYS_CLK, SRST, WR_EN;
    logic [4:0] WR_ADDR, RD_ADDR;
    logic [31:0] WR_DATA, v, last;
    wire [31:0] RD_DATA, SWEEP_VALUE;
    wire [9:0] SCALE_FACTOR;
    wire IO_UPDATE, PROFILE_PIN, RAMP_PIN, SCALE_BYPASS, CLEAR_PHASE, SYNC_CLK_OUT;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    logic sel = 1'b0;
    logic [4:0] ra[8] = '{5'h03, 5'h04, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h1f};
    logic [31:0] rv[8] = '{32'h0, 32'h0, 32'h0, 32'h0101, 32'h0, 32'h0, 32'h0, 32'h0};
    wire [31:0] mon = sel ? {22'h0, SCALE_FACTOR} : SWEEP_VALUE;
    sweep_and_amplitude_ramp i_dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR),
        .WR_DATA(WR_DATA), .IO_UPDATE(IO_UPDATE), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
        .PROFILE_PIN(PROFILE_PIN), .RAMP_PIN(RAMP_PIN), .SWEEP_VALUE(SWEEP_VALUE), .SCALE_FACTOR(SCALE_FACTOR),
        .SCALE_BYPASS(SCALE_BYPASS), .CLEAR_PHASE(CLEAR_PHASE), .SYNC_CLK_OUT(SYNC_CLK_OUT));
    pin_ctrl_model i_ctl (.SYS_CLK(SYS_CLK), .IO_UPDATE(IO_UPDATE), .PROFILE_PIN(PROFILE_PIN), .RAMP_PIN(RAMP_PIN));
    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        WR_EN <= 1'b1;
        WR_ADDR <= a;
        WR_DATA <= d;
        @(posedge SYS_CLK);
        WR_EN <= 1'b0;
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge SYS_CLK);
        RD_ADDR <= a;
        repeat (2) @(posedge SYS_CLK);
        #1 chk("rd_data", e, RD_DATA);
    endtask
    // Bounded waits: a stuck output ends the run instead of hanging it
    task wait_mon(input logic [31:0] e, input int lim);
        for (n = 0; mon !== e && n < lim; n++) @(posedge SYS_CLK) #1;
        chk("settled", e, mon);
        if (mon !== e) end_sim;
    endtask
    task wait_chg;
        last = mon;
        for (n = 0; mon === last && n < 3000; n++) @(posedge SYS_CLK) #1;
        if (n >= 3000) begin
            chk("no_change", last + 32'h1, mon);
            end_sim;
        end
    endtask
    // Spacing and size of one whole step, taken between two later changes
    task gap(input int e, input logic [31:0] es);
        wait_chg();
        v = mon;
        wait_chg();
        chk("step_gap", e, n);
        chk("step_size", es, mon - v);
    endtask
    initial begin
        SRST = 1'b1;
        WR_EN = 1'b0;
        WR_ADDR = 5'h00;
        WR_DATA = 32'h0;
        RD_ADDR = 5'h00;
        repeat (16) @(posedge SYS_CLK);
        SRST <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        chk("bypass", 32'h1, SCALE_BYPASS);
        wr(`ADDR_START_WORD, 32'h64);
        wr(`ADDR_END_WORD, 32'hb4);
        wr(`ADDR_RISE_STEP, 32'h10);
        wr(`ADDR_FALL_STEP, 32'h8);
        wr(`ADDR_INTERVALS, 32'h0302);
        wr(`ADDR_CHAN_CTRL, 32'h804000);
        rd(`ADDR_RISE_STEP, 32'h0);
        i_ctl.update();
        rd(`ADDR_INTERVALS, 32'h0302);
        wait_mon(32'h64, 100);
        i_ctl.pins(1'b1, 1'b0);
        gap(8, 32'h10);
        wait_mon(32'hb4, 500);
        repeat (60) @(posedge SYS_CLK);
        chk("hold_end", 32'hb4, mon);
        i_ctl.pins(1'b0, 1'b0);
        gap(12, -32'sd8);
        wr(`ADDR_FALL_STEP, 32'h4);
        i_ctl.update();
        gap(12, -32'sd4);
        wait_mon(32'h64, 1000);
        wr(`ADDR_CHAN_CTRL, 32'h80c000);
        i_ctl.update();
        i_ctl.pins(1'b1, 1'b0);
        wait_mon(32'hb4, 500);
        wait_mon(32'h64, 100);
        i_ctl.pins(1'b0, 1'b0);
        repeat (60) @(posedge SYS_CLK);
        chk("no_dwell_fall", 32'h64, mon);
        wr(`ADDR_CHAN_CTRL, 32'h80400a);
        i_ctl.update();
        i_ctl.pins(1'b1, 1'b0);
        repeat (100) @(posedge SYS_CLK);
        chk("held_clear", 32'h64, mon);
        chk("clear_phase", 32'h1, CLEAR_PHASE);
        wr(`ADDR_CHAN_CTRL, 32'h804000);
        i_ctl.update();
        chk("clear_phase", 32'h0, CLEAR_PHASE);
        // Auto clear on a profile rise must still let that rise start the sweep
        i_ctl.pins(1'b0, 1'b0);
        wr(`ADDR_CHAN_CTRL, 32'h804014);
        i_ctl.update();
        i_ctl.pins(1'b1, 1'b0);
        wait_mon(32'hb4, 500);
        sel = 1'b1;
        wr(`ADDR_AMP_CTRL, 32'h1155);
        i_ctl.update();
        rd(`ADDR_AMP_CTRL, 32'h1155);
        chk("bypass", 32'h0, SCALE_BYPASS);
        chk("manual", 32'h155, mon);
        for (int k = 0; k < 4; k++) begin
            wr(`ADDR_AMP_CTRL, 32'h021840 | (k << 14));
            i_ctl.update();
            rd(`ADDR_AMP_CTRL, 32'h021840 | (k << 14));
            wait_mon(32'h0, 3000);
            i_ctl.pins(1'b0, 1'b1);
            gap(8, 32'h1 << k);
            wait_mon(32'h40, 3000);
            i_ctl.pins(1'b0, 1'b0);
            wait_mon(32'h0, 3000);
        end
        end_sim();
    end
endmodule // testbench
`default_nettype wire
